/* File: verilog/gstat_top.sv */
// Gauge ramp shaping registers, hold-count dwell logic and the serial
// status framing of a dual gauge driver.
// Assumes an SPI master in mode 0 (sample on rising, shift on falling),
// with the serial clock idle while chip select is high.
// Behaviour
// RULE_01: Cut-in field 000 counts as 8, cut-in 64 steps above truncation.
// RULE_02: Cut-in field resets to 2, cut-in 16 steps above truncation.
// RULE_03: First hold position is cut-in value times 8 plus truncation.
// RULE_04: Last hold position is truncation plus 2.
// RULE_05: Each step below cut-in repeats hold-count times, 0 to 15.
// RULE_06: Hold-count field resets to 5.
// RULE_07: Master keeps hold product plus 225 minus truncation below 512.
// RULE_08: Gauge-select bit picks gauge 1 or 0; two writes set both.
// RULE_09: Master sends bit D11 of ramp write as zero.
// RULE_10: Ramp word is write-only: cut-in D10:D8, holds D7:D4, trunc D3:D0.
// RULE_11: Truncation field removes 0 to 15 bottom steps, resets to 0.
// RULE_12: Chip select low loads selected status word, shifted out MSB first.
// RULE_13: Frame accepted at chip select rise only if length nonzero, 16-multiple.
// RULE_14: Chip select high tri-states output and lets status update again.
// RULE_15: Fault flags stay latched until device status is shifted out.
// RULE_16: Invalid-length frame leaves faults set for the next valid frame.
// RULE_17: Pointer status bits always show live state.
// RULE_18: Bits after the first 16 echo the bits received since select.
// RULE_19: Status-select field of last valid enable command picks the word.
// RULE_20: Ramp motion starts and ends at truncation plus one.
// RULE_21: Hold counts are dwells at one step before moving down the ramp.
`timescale 1ns/10ps
module gstat_top
    import gstat_pkg::*;
(
    input wire logic clk_i, // Core clock, 250 MHz.
    input wire logic srst_i, // Synchronous reset, active high.
    input wire logic sclk_i, // Serial link clock from the master.
    input wire logic cs_n_i, // Chip select, active low.
    input wire logic si_i, // Serial data in.
    output logic so_o, // Serial data out.
    output logic so_oe_o, // Serial output enable, high while driving.
    input wire gstat_status_src_t status_i, // Status sources, clk_i domain.
    input wire logic [1:0] step_req_i, // Per gauge deceleration step pulse.
    input wire logic [13:0] vel_pos_i, // Per gauge velocity position, 7 bits.
    output logic [1:0] step_down_o, // Per gauge move-down pulse.
    output logic [1:0] step_hold_o, // Per gauge dwell pulse.
    output gstat_ramp_pos_t [1:0] ramp_pos_o, // Derived ramp positions.
    output logic [3:0] status_sel_o, // Current status selection.
    output logic [WORD_W-1:0] cmd_word_o, // Last accepted command word.
    output logic cmd_valid_o // Pulse when a command word is accepted.
);

    // Link domain: counters are cleared by chip select, so they start fresh
    // every frame without needing a serial clock edge outside the frame.
    logic [3:0] bit_low;
    logic bit_any;
    logic [WORD_W-1:0] rx_shift;
    logic so_q;
    logic so_started;
    logic past_word;
    logic frame_len_ok;
    logic [WORD_W-1:0] frame_rx;

    // Core domain state.
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic [WORD_W-1:0] snap_word;
    logic [3:0] snap_sel;
    logic [WORD_W-1:0] fault_flags;
    logic [3:0] status_sel;
    gstat_ramp_cfg_t ramp_cfg [2];
    logic frame_end;
    logic frame_ok;
    logic [WORD_W-1:0] frame_word;
    logic [WORD_W-1:0] next_status_word;
    logic [WORD_W-1:0] fault_clear;

    // Count received bits: low four bits plus a flag once any bit arrived.
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_low <= 4'h0;
            bit_any <= 1'b0;
            past_word <= 1'b0;
        end else begin
            bit_low <= bit_low + 4'h1;
            bit_any <= 1'b1;
            // Once sixteen bits are in, every later output bit is echo.
            if (bit_low == 4'hF) begin
                past_word <= 1'b1; // [RULE_18]
            end
        end
    end

    // The receive shifter is sixteen deep, so its top bit is exactly the
    // bit received sixteen clocks ago, which is what gets echoed.
    always_ff @(posedge sclk_i) begin
        rx_shift <= {rx_shift[WORD_W-2:0], si_i};
    end

    // Shift out on falling edges: snapshot bits first, then the echo.
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_q <= 1'b0;
            so_started <= 1'b0;
        end else begin
            so_started <= 1'b1;
            if (!bit_any) begin
                so_q <= snap_word[WORD_W-1]; // [RULE_12]
            end else if (past_word) begin
                so_q <= rx_shift[WORD_W-1]; // [RULE_18]
            end else begin
                so_q <= snap_word[4'hF - bit_low]; // [RULE_12]
            end
        end
    end

    // Before the first falling edge the MSB sits on the pin already.
    // Drive only while selected; high impedance is formed outside.
    assign so_oe_o = ~cs_n_i; // [RULE_14]
    always_comb begin
        if (cs_n_i) begin
            so_o = 1'b0;
        end else if (so_started) begin
            so_o = so_q;
        end else begin
            so_o = snap_word[WORD_W-1]; // [RULE_12]
        end
    end

    // Chip select into the core domain; only cs_s2 and cs_s3 are read.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    // The counters clear as chip select rises, so the length verdict and
    // the last word are captured on that same edge from the old values.
    // This is a hold path against the clearing edge that layout must keep.
    always_ff @(posedge cs_n_i) begin
        frame_len_ok <= bit_any & (bit_low == 4'h0); // [RULE_13]
        frame_rx <= rx_shift;
    end

    // By the synchronised rising edge the captured values have stood for
    // two core clocks, and they stand until the next frame ends.
    assign frame_end = cs_s2 & ~cs_s3;
    assign frame_ok = frame_len_ok;
    assign frame_word = frame_rx;

    // Assemble the selected status word from live and latched sources.
    always_comb begin
        if (!status_sel[3]) begin
            next_status_word = (status_i.dev_live & ~FAULT_MASK)
                | (fault_flags & FAULT_MASK); // [RULE_15] [RULE_17]
        end else if (!status_sel[2]) begin
            next_status_word = status_i.rtz_acc;
        end else if (status_sel == SSEL_POS0) begin
            next_status_word = status_i.pos0; // [RULE_17]
        end else if (status_sel == SSEL_POS1) begin
            next_status_word = status_i.pos1; // [RULE_17]
        end else begin
            next_status_word = status_i.vel; // [RULE_17]
        end
    end

    // The snapshot follows the sources while deselected and freezes for the
    // frame. A chip select fall closer than two core clocks to the first
    // serial edge could catch it mid-update; the link period makes that moot.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            snap_word <= '0;
            snap_sel <= SSEL_RST;
        end else if (cs_s2) begin
            snap_word <= next_status_word; // [RULE_14]
            snap_sel <= status_sel;
        end
    end

    // Faults clear only after a valid frame that carried device status;
    // a new event in that same cycle wins over the clear.
    always_comb begin
        fault_clear = '0;
        if (frame_end && frame_ok && !snap_sel[3]) begin
            fault_clear = snap_word & FAULT_MASK; // [RULE_15] [RULE_16]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fault_flags <= '0;
        end else begin
            fault_flags <= (fault_flags & ~fault_clear)
                | (status_i.fault_set & FAULT_MASK); // [RULE_15]
        end
    end

    // Accepted command words: status selection and ramp settings.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_sel <= SSEL_RST;
        end else if (frame_end && frame_ok
                && frame_word[ADDR_MSB:ADDR_LSB] == ENSEL_ADDR) begin
            status_sel <= frame_word[SSEL_MSB:SSEL_LSB]; // [RULE_19]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmd_word_o <= '0;
            cmd_valid_o <= 1'b0;
        end else begin
            cmd_valid_o <= frame_end & frame_ok; // [RULE_13]
            if (frame_end && frame_ok) begin
                cmd_word_o <= frame_word;
            end
        end
    end

    assign status_sel_o = status_sel;

    // Per gauge ramp registers, derived positions and dwell control.
    for (genvar g = 0; g < 2; g++) begin : g_gauge
        logic [3:0] hcp_eff;
        logic [3:0] rep_cnt;
        logic [6:0] vpos;
        logic in_hold;

        // Write-only: nothing reads these back over the link.
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                ramp_cfg[g] <= '{cutin_point_field: HCP_RST, hc: HC_RST,
                    rs: RS_RST}; // [RULE_02] [RULE_06] [RULE_11]
            end else if (frame_end && frame_ok
                    && frame_word[ADDR_MSB:ADDR_LSB] == RAMP_SEL_ADDR
                    && !frame_word[MBZ_BIT]
                    && frame_word[GSEL_BIT] == 1'(g)) begin // [RULE_08]
                ramp_cfg[g] <= '{cutin_point_field: frame_word[HCP_MSB:HCP_LSB],
                    hc: frame_word[HC_MSB:HC_LSB],
                    rs: frame_word[RS_MSB:RS_LSB]}; // [RULE_10]
            end
        end

        // A zero cut-in field means eight groups of eight steps.
        assign hcp_eff = (ramp_cfg[g].cutin_point_field == 3'h0) ? HCP_ZERO_VAL
            : {1'b0, ramp_cfg[g].cutin_point_field}; // [RULE_01]

        // No reset of their own: the positions follow the settings one
        // clock later, so they already show the defaults during reset.
        always_ff @(posedge clk_i) begin
            ramp_pos_o[g].cutin_pos <= {hcp_eff, 3'h0}
                + {3'h0, ramp_cfg[g].rs}; // [RULE_03]
            ramp_pos_o[g].last_hold_pos <= {3'h0, ramp_cfg[g].rs}
                + LAST_HOLD_OFS; // [RULE_04]
            ramp_pos_o[g].start_pos <= {3'h0, ramp_cfg[g].rs}
                + START_OFS; // [RULE_20]
            ramp_pos_o[g].hold_count <= ramp_cfg[g].hc; // [RULE_05]
        end

        // The settings limit on the hold product is the master's to keep;
        // the dwell counter is four bits and cannot overflow regardless.
        assign vpos = vel_pos_i[g*7 +: 7];
        assign in_hold = (vpos <= ramp_pos_o[g].cutin_pos)
            && (vpos >= ramp_pos_o[g].last_hold_pos); // [RULE_03] [RULE_04]

        // On each step request either dwell again or move down one step.
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                rep_cnt <= 4'h0;
                step_down_o[g] <= 1'b0;
                step_hold_o[g] <= 1'b0;
            end else begin
                step_down_o[g] <= 1'b0;
                step_hold_o[g] <= 1'b0;
                if (step_req_i[g]) begin
                    if (in_hold && rep_cnt < ramp_pos_o[g].hold_count) begin
                        rep_cnt <= rep_cnt + 4'h1; // [RULE_21] [RULE_05]
                        step_hold_o[g] <= 1'b1;
                    end else begin
                        rep_cnt <= 4'h0;
                        step_down_o[g] <= 1'b1; // [RULE_21]
                    end
                end
            end
        end
    end

endmodule : gstat_top

/* File: verilog/gstat_pkg.sv */
// Shared constants and types for the gauge ramp configuration and the
// serial status framing block.
// Assumes 16-bit serial words: 3-bit address in the top bits, 13-bit data.
package gstat_pkg;

    // Serial word layout.
    localparam int WORD_W = 16;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 13;
    localparam int GSEL_BIT = 12;
    localparam int MBZ_BIT = 11;
    localparam int HCP_MSB = 10;
    localparam int HCP_LSB = 8;
    localparam int HC_MSB = 7;
    localparam int HC_LSB = 4;
    localparam int RS_MSB = 3;
    localparam int RS_LSB = 0;
    localparam int SSEL_MSB = 11;
    localparam int SSEL_LSB = 8;

    // Register addresses carried in the word.
    localparam logic [2:0] RAMP_SEL_ADDR = 3'h5;
    localparam logic [2:0] ENSEL_ADDR = 3'h2;

    // Reset values and fixed offsets of the ramp shaping.
    localparam logic [2:0] HCP_RST = 3'h2;
    localparam logic [3:0] HC_RST = 4'h5;
    localparam logic [3:0] RS_RST = 4'h0;
    localparam logic [3:0] HCP_ZERO_VAL = 4'h8;
    localparam logic [6:0] START_OFS = 7'h01;
    localparam logic [6:0] LAST_HOLD_OFS = 7'h02;

    // Status selection codes and the latched fault bits of device status.
    localparam logic [3:0] SSEL_RST = 4'h0;
    localparam logic [3:0] SSEL_POS0 = 4'hC;
    localparam logic [3:0] SSEL_POS1 = 4'hD;
    localparam logic [15:0] FAULT_MASK = 16'h03F3;

    // One gauge's ramp settings as written.
    typedef struct packed {
        logic [2:0] cutin_point_field;
        logic [3:0] hc;
        logic [3:0] rs;
    } gstat_ramp_cfg_t;

    // Derived velocity positions for one gauge.
    typedef struct packed {
        logic [6:0] start_pos;
        logic [6:0] cutin_pos;
        logic [6:0] last_hold_pos;
        logic [3:0] hold_count;
    } gstat_ramp_pos_t;

    // Status sources presented by the rest of the device.
    typedef struct packed {
        logic [15:0] dev_live;
        logic [15:0] fault_set;
        logic [15:0] rtz_acc;
        logic [15:0] pos0;
        logic [15:0] pos1;
        logic [15:0] vel;
    } gstat_status_src_t;

endpackage : gstat_pkg

/* File: tb/gstat_chk.sv */
// Assertion checker of the ramp and serial framing block.
// Sees only top-level ports; all checks run on the core clock.
`timescale 1ns/10ps
module gstat_chk
    import gstat_pkg::*;
(
    input wire logic clk_i, // Core clock.
    input wire logic srst_i, // Synchronous reset.
    input wire logic cs_n_i, // Chip select, active low.
    input wire logic so_o, // Serial data out.
    input wire logic so_oe_o, // Serial output enable.
    input wire logic [1:0] step_req_i, // Step requests.
    input wire logic [13:0] vel_pos_i, // Velocity positions.
    input wire logic [1:0] step_down_o, // Move-down pulses.
    input wire logic [1:0] step_hold_o, // Dwell pulses.
    input wire gstat_ramp_pos_t [1:0] ramp_pos_o, // Ramp positions.
    input wire logic [3:0] status_sel_o, // Status selection.
    input wire logic cmd_valid_o // Accepted frame pulse.
);
    // One domain, so clock and reset are given once for all checks.
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Distance from start to cut-in plus one is the cut-in offset.
    gstat_ramp_pos_t p0;
    logic [6:0] ofs0;
    assign p0 = ramp_pos_o[0];
    assign ofs0 = p0.cutin_pos - p0.start_pos + 7'h01;
    sequence s_no_valid;
        !cmd_valid_o [*2];
    endsequence
    sequence s_one_step;
        step_hold_o[0] ^ step_down_o[0];
    endsequence
    a_reset_defaults: assert property (
        $fell(srst_i) |-> p0 == {7'h01, 7'h10, 7'h02, 4'h5})
        else $error("ramp defaults wrong after reset");
    a_start_last: assert property (
        p0.start_pos + 7'h01 == p0.last_hold_pos)
        else $error("start and last hold positions apart");
    a_cutin_offset: assert property (
        ofs0[2:0] == 3'h0 && ofs0 != 7'h00 && ofs0 <= 7'h40)
        else $error("cut-in offset not a multiple of 8");
    a_step_answer: assert property (step_req_i[0] |=> s_one_step)
        else $error("step request without one answer");
    a_no_spurious: assert property (
        !step_req_i[0] |=> !(step_hold_o[0] || step_down_o[0]))
        else $error("step pulse without request");
    a_hold_window: assert property (
        step_hold_o[0] |->
        $past(vel_pos_i[6:0]) >= $past(p0.last_hold_pos)
        && $past(vel_pos_i[6:0]) <= $past(p0.cutin_pos))
        else $error("dwell outside hold window");
    a_oe_follows: assert property (so_oe_o == !cs_n_i)
        else $error("output enable not following select");
    a_so_idle: assert property (cs_n_i |-> !so_o)
        else $error("serial out active while deselected");
    a_valid_delay: assert property ($rose(cs_n_i) |-> s_no_valid)
        else $error("frame accepted too early");
    a_sel_holds: assert property (
        $changed(status_sel_o) |-> cmd_valid_o)
        else $error("status selection changed without frame");
    a_cfg_holds: assert property (
        $changed(ramp_pos_o) |-> $past(cmd_valid_o))
        else $error("ramp settings changed without frame");
endmodule : gstat_chk
bind gstat_top gstat_chk chk_u (.*);

/* File: tb/gstat_spi_master.sv */
// Serial master model, mode 0, clock standing low between frames.
// Frames are driven by tasks called from the bench.
`timescale 1ns/10ps
module gstat_spi_master (
    output logic sclk_o, // Serial clock.
    output logic cs_n_o, // Chip select, active low.
    output logic si_o, // Data to the device.
    input wire logic so_i // Data from the device.
);
    localparam realtime HALF = 62.5;
    // Chip select rises once just after time zero, so the link counters
    // see their clearing edge even if the time-zero event is missed.
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b0;
        si_o = 1'b0;
        #1;
        cs_n_o = 1'b1;
    end
    // One frame of nbits bits, first bit from data[nbits-1].
    task automatic xfer(input logic [31:0] data, input int nbits,
                        output logic [31:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        #HALF;
        for (int i = nbits - 1; i >= 0; i--) begin
            si_o = data[i];
            #HALF;
            sclk_o = 1'b1;
            rx = {rx[30:0], so_i};
            #HALF;
            sclk_o = 1'b0;
        end
        #HALF;
        cs_n_o = 1'b1;
        // A released line must not keep its last value.
        si_o = ~si_o;
        #(2 * HALF);
    endtask : xfer
endmodule : gstat_spi_master

/* File: tb/gstat_top_tb.sv */
// Self-checking bench of the gauge ramp and serial status block.
// Serial side through the master model, core inputs driven directly.
`timescale 1ns/10ps
module gstat_top_tb;
    import gstat_pkg::*;
    logic clk_i = 1'b0, srst_i = 1'b1, sclk, cs_n, si, so, oe, cvalid, g;
    logic [1:0] req, down, hold;
    logic [13:0] vel;
    logic [3:0] ssel, rs, hc, sel, step_exp;
    logic [2:0] cutin_point_field;
    logic [15:0] cword;
    logic [31:0] lf = 32'h79A4, rx, dw;
    gstat_status_src_t status;
    gstat_ramp_pos_t [1:0] rpos;
    gstat_ramp_pos_t e0;
    logic [15:0] exp_q[$];
    int errors = 0, compares = 0, cyc = 0, d;
    always #2 clk_i = ~clk_i;
    gstat_spi_master m_u (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
    gstat_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(oe), .status_i(status),
        .step_req_i(req), .vel_pos_i(vel), .step_down_o(down),
        .step_hold_o(hold), .ramp_pos_o(rpos), .status_sel_o(ssel),
        .cmd_word_o(cword), .cmd_valid_o(cvalid));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // Only whole-word frames are expected to be accepted.
    task automatic frame(input logic [31:0] dat, input int n);
        if (n != 0 && n % 16 == 0) exp_q.push_back(dat[15:0]);
        m_u.xfer(dat, n, rx);
        repeat (8) @(posedge clk_i);
        #1;
        check({30'h0, oe, so}, 32'h0);
    endtask : frame
    // Each accepted frame is matched against the oldest expected word.
    always @(negedge clk_i) begin
        if (cvalid === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0);
            else check(cword, exp_q.pop_front());
        end
    end
    // A hang is cut short well above the expected run length.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        status = '0;
        req = '0;
        vel = '0;
        repeat (20) @(posedge clk_i);
        #1 srst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        // Packed defaults: start 1, cut-in 16, last hold 2, hold count 5.
        check(rpos[1], 32'h48025);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            lf = lfsr_next(lf);
            g = k[0];
            cutin_point_field = k[2:0];
            rs = lf[3:0];
            hc = {2'b00, lf[5:4]}; // Keeps the hold budget below 512.
            d = (cutin_point_field == 3'h0) ? 64 : cutin_point_field * 8;
            d = d + rs;
            dw = {16'h0, RAMP_SEL_ADDR, g, 1'b0, cutin_point_field, hc, rs};
            frame(dw, 16);
            dw = {{3'h0, rs} + 7'h01, 7'(d), {3'h0, rs} + 7'h02, hc};
            if (g == 1'b0) e0 = dw[24:0];
            check(rpos[g], dw);
        end
        frame({16'h0, RAMP_SEL_ADDR, 2'b01, 3'h1, 4'h3, 4'h0}, 16);
        check(rpos[0], e0);
        frame({16'h0, RAMP_SEL_ADDR, 2'b00, 3'h1, 4'h3, 4'h0}, 16);
        check(rpos[0], {7'h01, 7'h08, 7'h02, 4'h3});
        frame({16'h0, RAMP_SEL_ADDR, 2'b10, 3'h1, 4'h3, 4'h0}, 16);
        check(rpos[1], {7'h01, 7'h08, 7'h02, 4'h3});
        $display("test ramp done");
        // Both gauges dwell three times, then gauge 0 leaves its window.
        vel = 14'h0285;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_i);
            #1 req = 2'b11;
            vel = (k == 4) ? 14'h0289 : 14'h0285;
            @(posedge clk_i);
            #1 req = 2'b00;
            step_exp = (k == 4) ? 4'h9 : {k < 3, k < 3, k == 3, k == 3};
            check({hold, down}, step_exp);
        end
        $display("test dwell done");
        lf = lfsr_next(lf);
        frame(32'h00A5, 8);
        frame(32'h0, 0);
        frame({lf[15:0], 3'h7, lf[12:0]}, 32);
        check(rx, {16'h0, lf[15:0]});
        $display("test length done");
        for (int k = 0; k < 4; k++) begin
            lf = lfsr_next(lf);
            status = {32'h0, lf[15:0], ~lf[15:0], lf[31:16], ~lf[31:16]};
            sel = (k == 0) ? 4'h8 : (k == 1) ? SSEL_POS0
                : (k == 2) ? SSEL_POS1 : 4'hE;
            frame({16'h0, ENSEL_ADDR, 1'b0, sel, 8'h00}, 16);
            check(ssel, sel);
            frame(32'hE000, 16);
            check(rx[15:0], status[63 - 16 * k -: 16]);
        end
        $display("test select done");
        frame({16'h0, ENSEL_ADDR, 1'b0, 4'h0, 8'h00}, 16);
        status = '0;
        status.dev_live = lf[15:0] & ~FAULT_MASK;
        status.fault_set = 16'h0201;
        @(posedge clk_i);
        #1 status.fault_set = 16'h0;
        frame(32'h0, 8);
        check(rx[7:0], status.dev_live[15:8] | 8'h02);
        frame(32'hE000, 16);
        check(rx[15:0], status.dev_live | 16'h0201);
        frame(32'hE000, 16);
        check(rx[15:0], status.dev_live);
        $display("test faults done");
        if (exp_q.size() != 0) check(exp_q.size(), 0);
        report_and_stop();
    end
endmodule : gstat_top_tb
